/* rtl/les_defs.svh */
// Purpose: offsets, field positions, reset values for the link error block
// Assumes: 32-bit register port, word-aligned byte offsets
// Notes:   included by the design file and by the bench
`ifndef LES_DEFS_SVH
`define LES_DEFS_SVH

// register byte offsets
`define LES_CMD       8'h00
`define LES_LSTS      8'h04
`define LES_DCTL      8'h08
`define LES_DSTS      8'h0C
`define LES_DCAP      8'h10
`define LES_USTS      8'h14
`define LES_UMSK      8'h18
`define LES_USEV      8'h1C
`define LES_CSTS      8'h20
`define LES_HDR0      8'h24
`define LES_IRQ_STS   8'h34
`define LES_IRQ_CLR   8'h38
`define LES_IRQ_EN    8'h3C

// field positions
`define LES_CMD_SERR   8
`define LES_LSTS_SSE   14
`define LES_DCTL_COR   0
`define LES_DCTL_NF    1
`define LES_DCTL_FAT   2
`define LES_DCTL_UR    3
`define LES_DCAP_RBER  15
`define LES_U_FCP      13
`define LES_U_OVF      17
`define LES_U_MAL      18
`define LES_U_UR       20
`define LES_U_PFX      25
`define LES_C_ADV      13

// reset values and strap
`define LES_USEV_RST   32'h0006_2000
`define LES_UMSK_RST   32'h0000_0000
`define LES_RBER_IMPL  1'b1

`endif

/* rtl/les_pkg.sv */
// Purpose: types shared by the link error block
// Assumes: single clock domain
// Notes:   constants live in les_defs.svh
package les_pkg;

    // error events reported by the packet checkers, one-cycle pulses
    typedef struct packed {
        logic rx_ovf;
        logic fc_err;
        logic malformed;
        logic pfx_blk;
        logic pfx_adv;
        logic ur;
        logic ur_posted;
    } les_err_t;

    typedef enum logic [1:0] {
        LES_MSG_COR = 2'b00,
        LES_MSG_NF  = 2'b01,
        LES_MSG_FAT = 2'b11
    } les_kind_t;

    // error message request toward the upstream link
    typedef struct packed {
        logic      valid;
        les_kind_t kind;
    } les_msg_t;

endpackage

/* rtl/les_top.sv */
// Purpose: classify link errors, log headers, set native and legacy status
// Assumes: error pulses and header come from logic on i_core_clk
// Notes:   one message per cycle, the most severe one wins
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "les_defs.svh"

module les_top (
    input  wire logic             i_core_clk, // core clock, 40 MHz
    input  wire logic             i_rstn,     // async reset, active low
    input  wire les_pkg::les_err_t i_err,     // error event pulses
    input  wire logic [127:0]     i_hdr,      // prefix/header of the offending packet
    input  wire logic [7:0]       i_addr,     // register byte address
    input  wire logic [31:0]      i_wdata,    // register write data
    input  wire logic             i_wr,       // write strobe
    input  wire logic             i_rd,       // read strobe
    output logic [31:0]           o_rdata,    // read data, cycle after strobe
    output les_pkg::les_msg_t     o_msg,      // error message request
    output logic                  o_irq       // level interrupt
);
    import les_pkg::*;

    // ********************************************
    // registers
    // ********************************************
    logic [31:0]  cmd_r, lsts_r, dctl_r, dsts_r, usts_r, umsk_r, usev_r, csts_r;
    logic [127:0] hdr_r;
    logic         hdr_vld_r;
    logic [3:0]   irq_sts_r, irq_en_r;
    logic [31:0]  rdata_r;
    les_msg_t     msg_r;
    logic         irq_r;
    logic [31:0]  lsts_nxt, dsts_nxt, usts_nxt, csts_nxt, rdata_nxt;
    logic [3:0]   irq_sts_nxt;
    les_msg_t     msg_nxt;

    // ********************************************
    // address decode
    // ********************************************
    wire w_cmd  = i_wr && (i_addr == `LES_CMD);
    wire w_lsts = i_wr && (i_addr == `LES_LSTS);
    wire w_dctl = i_wr && (i_addr == `LES_DCTL);
    wire w_dsts = i_wr && (i_addr == `LES_DSTS);
    wire w_usts = i_wr && (i_addr == `LES_USTS);
    wire w_umsk = i_wr && (i_addr == `LES_UMSK);
    wire w_usev = i_wr && (i_addr == `LES_USEV);
    wire w_csts = i_wr && (i_addr == `LES_CSTS);
    wire w_iclr = i_wr && (i_addr == `LES_IRQ_CLR);
    wire w_ien  = i_wr && (i_addr == `LES_IRQ_EN);

    // ********************************************
    // error classification
    // ********************************************
    wire serr_en = cmd_r[`LES_CMD_SERR];
    wire cor_en  = dctl_r[`LES_DCTL_COR];
    wire nf_en   = dctl_r[`LES_DCTL_NF];
    wire fat_en  = dctl_r[`LES_DCTL_FAT];
    wire ur_en   = dctl_r[`LES_DCTL_UR];
    wire rber    = `LES_RBER_IMPL;

    // uncorrectable events other than unsupported request
    logic [31:0] uevt;
    always_comb begin
        uevt = 32'h0000_0000;
        uevt[`LES_U_OVF] = i_err.rx_ovf;
        uevt[`LES_U_FCP] = i_err.fc_err;
        uevt[`LES_U_MAL] = i_err.malformed;
        uevt[`LES_U_PFX] = i_err.pfx_blk;
    end
    wire [31:0] ulive  = uevt & ~umsk_r;
    wire        u_fat  = |(ulive & usev_r);
    wire        u_nf   = |(ulive & ~usev_r);
    wire        adv    = i_err.pfx_adv;

    // unsupported request path
    wire ur_msk  = umsk_r[`LES_U_UR];
    wire ur_sev  = usev_r[`LES_U_UR];
    wire ur_live = i_err.ur && !ur_msk;
    // legacy functions: reporting enable is mandatory
    wire ur_old  = ur_live && ur_en;
    // role-based: system-error enable also opens, unless masked
    wire ur_rb   = ur_live && (ur_en || serr_en);
    // role-based non-posted non-fatal is advisory: correctable only
    wire ur_advc = rber && ur_live && !i_err.ur_posted && !ur_sev;
    wire ur_gate = rber ? (ur_rb && !ur_advc) : ur_old;
    wire ur_fat  = ur_gate && ur_sev;
    wire ur_nf   = ur_gate && !ur_sev;
    wire ur_cor  = ur_advc && ur_en;

    // message selection per severity enable
    wire send_fat = (u_fat || ur_fat) && (fat_en || serr_en);
    wire send_nf  = (u_nf || ur_nf) && (nf_en || serr_en) && !send_fat;
    wire send_cor = (adv || ur_cor) && cor_en && !send_fat && !send_nf;

    always_comb begin
        msg_nxt.valid = send_fat || send_nf || send_cor;
        if (send_fat) begin
            msg_nxt.kind = LES_MSG_FAT;
        end else if (send_nf) begin
            msg_nxt.kind = LES_MSG_NF;
        end else begin
            msg_nxt.kind = LES_MSG_COR;
        end
    end

    // ********************************************
    // status update, set wins over clear
    // ********************************************
    wire [31:0] uset = uevt | ({31'h0, i_err.ur} << `LES_U_UR);
    wire [31:0] cset = {31'h0, adv || ur_advc} << `LES_C_ADV;
    wire any_fat = |(uevt & usev_r) || (i_err.ur && ur_sev);
    wire any_nf  = |(uevt & ~usev_r) || (i_err.ur && !ur_sev && !ur_advc);
    wire any_cor = adv || ur_advc;
    wire [31:0] dset = {28'h0, i_err.ur, any_fat, any_nf, any_cor};
    // legacy system error bit gated by the command bit only
    wire [31:0] lset = {31'h0, (send_fat || send_nf) && serr_en} << `LES_LSTS_SSE;

    // each status register cleared only by its own write
    assign usts_nxt = (usts_r & ~(w_usts ? i_wdata : 32'h0000_0000)) | uset;
    assign csts_nxt = (csts_r & ~(w_csts ? i_wdata : 32'h0000_0000)) | cset;
    assign dsts_nxt = (dsts_r & ~(w_dsts ? i_wdata : 32'h0000_0000)) | dset;
    assign lsts_nxt = (lsts_r & ~(w_lsts ? i_wdata : 32'h0000_0000)) | lset;

    // header log captures the first logged error until status is cleared
    wire hdr_take = (i_err.malformed || i_err.pfx_blk || adv) && !hdr_vld_r;
    wire hdr_free = w_usts && ((i_wdata & usts_r) != 32'h0000_0000);

    // ********************************************
    // interrupts: message kinds and header capture
    // ********************************************
    wire [3:0] irq_set = {hdr_take, send_fat, send_nf, send_cor};
    assign irq_sts_nxt = (irq_sts_r & ~(w_iclr ? i_wdata[3:0] : 4'h0)) | irq_set;

    // ********************************************
    // read mux
    // ********************************************
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (!i_rd) begin
            rdata_nxt = 32'h0000_0000;
        end else if (i_addr == `LES_CMD) begin
            rdata_nxt = cmd_r;
        end else if (i_addr == `LES_LSTS) begin
            rdata_nxt = lsts_r;
        end else if (i_addr == `LES_DCTL) begin
            rdata_nxt = dctl_r;
        end else if (i_addr == `LES_DSTS) begin
            rdata_nxt = dsts_r;
        end else if (i_addr == `LES_DCAP) begin
            rdata_nxt = {31'h0, rber} << `LES_DCAP_RBER;
        end else if (i_addr == `LES_USTS) begin
            rdata_nxt = usts_r;
        end else if (i_addr == `LES_UMSK) begin
            rdata_nxt = umsk_r;
        end else if (i_addr == `LES_USEV) begin
            rdata_nxt = usev_r;
        end else if (i_addr == `LES_CSTS) begin
            rdata_nxt = csts_r;
        end else if (i_addr == `LES_HDR0) begin
            rdata_nxt = hdr_r[31:0];
        end else if (i_addr == `LES_HDR0 + 8'h04) begin
            rdata_nxt = hdr_r[63:32];
        end else if (i_addr == `LES_HDR0 + 8'h08) begin
            rdata_nxt = hdr_r[95:64];
        end else if (i_addr == `LES_HDR0 + 8'h0C) begin
            rdata_nxt = hdr_r[127:96];
        end else if (i_addr == `LES_IRQ_STS) begin
            rdata_nxt = {28'h0, irq_sts_r};
        end else if (i_addr == `LES_IRQ_EN) begin
            rdata_nxt = {28'h0, irq_en_r};
        end
    end

    // ********************************************
    // control registers
    // ********************************************
    // command: only the system-error enable is kept
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmd_r <= 32'h0000_0000;
        end else if (w_cmd) begin
            cmd_r <= i_wdata & (32'h0000_0001 << `LES_CMD_SERR);
        end
    end

    // device control: the four reporting enables
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            dctl_r <= 32'h0000_0000;
        end else if (w_dctl) begin
            dctl_r <= {28'h000_0000, i_wdata[3:0]};
        end
    end

    // uncorrectable mask, read back as written
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            umsk_r <= `LES_UMSK_RST;
        end else if (w_umsk) begin
            umsk_r <= i_wdata;
        end
    end

    // uncorrectable severity, a set bit means fatal
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            usev_r <= `LES_USEV_RST;
        end else if (w_usev) begin
            usev_r <= i_wdata;
        end
    end

    // interrupt enables
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_en_r <= 4'h0;
        end else if (w_ien) begin
            irq_en_r <= i_wdata[3:0];
        end
    end

    // ********************************************
    // status and log registers
    // ********************************************
    // legacy status
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lsts_r <= 32'h0000_0000;
        end else begin
            lsts_r <= lsts_nxt;
        end
    end

    // device status
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            dsts_r <= 32'h0000_0000;
        end else begin
            dsts_r <= dsts_nxt;
        end
    end

    // uncorrectable status
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            usts_r <= 32'h0000_0000;
        end else begin
            usts_r <= usts_nxt;
        end
    end

    // correctable status
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            csts_r <= 32'h0000_0000;
        end else begin
            csts_r <= csts_nxt;
        end
    end

    // header log holds the first capture until it is freed
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hdr_r     <= 128'h0;
            hdr_vld_r <= 1'b0;
        end else begin
            if (hdr_take) hdr_r <= i_hdr;
            hdr_vld_r <= hdr_take || (hdr_vld_r && !hdr_free);
        end
    end

    // interrupt status and the registered level
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_sts_r <= 4'h0;
            irq_r     <= 1'b0;
        end else begin
            irq_sts_r <= irq_sts_nxt;
            irq_r     <= |(irq_sts_nxt & irq_en_r);
        end
    end

    // read data, zero outside the answer cycle
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // message request, one cycle per message
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            msg_r <= '0;
        end else begin
            msg_r <= msg_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_msg   = msg_r;
    assign o_irq   = irq_r;

    // ********************************************
    // assertions
    // ********************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    // message classes and header log
    ovf_fatal_a: assert property ((i_err.rx_ovf || i_err.fc_err) && !(|umsk_r) && fat_en
        && usev_r == `LES_USEV_RST |=> o_msg.valid && o_msg.kind == LES_MSG_FAT)
        else $error("overflow did not send fatal message");
    mal_log_a: assert property (i_err.malformed && !hdr_vld_r |=> hdr_r == $past(i_hdr)
        && usts_r[`LES_U_MAL])
        else $error("malformed packet header not logged");
    hdr_hold_a: assert property (hdr_vld_r |=> $stable(hdr_r))
        else $error("logged header overwritten");
    pfx_nf_a: assert property (i_err.pfx_blk && !usev_r[`LES_U_PFX] && !umsk_r[`LES_U_PFX] && nf_en
        && !any_fat |=> o_msg.valid && o_msg.kind == LES_MSG_NF)
        else $error("prefix block did not send non-fatal");
    adv_cor_a: assert property (i_err.pfx_adv && cor_en && uevt == 32'h0 && !i_err.ur
        |=> o_msg.valid && o_msg.kind == LES_MSG_COR)
        else $error("advisory block did not send correctable");
    det_set_a: assert property (i_err.ur |=> usts_r[`LES_U_UR] && dsts_r[3])
        else $error("unsupported request status not set");
    native_cmd_a: assert property (i_err.malformed && !serr_en |=> usts_r[`LES_U_MAL]
        && (dsts_r[`LES_DCTL_FAT] || dsts_r[`LES_DCTL_NF]))
        else $error("native status gated by command");
    // unsupported request path, then legacy status kept across a native clear
    ur_gate_a: assert property (i_err.ur && !ur_en && !serr_en && uevt == 32'h0 && !adv
        |=> !o_msg.valid)
        else $error("disabled request still reported");
    ur_np_a: assert property (i_err.ur && !i_err.ur_posted && serr_en && !ur_en && !cor_en
        && !ur_sev && uevt == 32'h0 && !adv |=> !o_msg.valid)
        else $error("non-posted request sent a message");
    ur_adv_a: assert property (i_err.ur && !i_err.ur_posted && !ur_sev && !ur_msk && ur_en && cor_en
        && uevt == 32'h0 |=> o_msg.valid && o_msg.kind == LES_MSG_COR)
        else $error("advisory request did not send correctable");
    ur_post_a: assert property (i_err.ur && i_err.ur_posted && serr_en && !ur_msk && !ur_sev
        && uevt == 32'h0 |=> o_msg.valid && o_msg.kind == LES_MSG_NF)
        else $error("posted request missed non-fatal");
    ur_mask_a: assert property (i_err.ur && ur_msk && uevt == 32'h0 && !adv |=> !o_msg.valid)
        else $error("masked request still reported");
    lsts_keep_a: assert property (w_usts && !w_lsts |=> lsts_r == ($past(lsts_r) | $past(lset)))
        else $error("legacy status changed by native clear");
    // status independence and register port
    usts_keep_a: assert property (w_lsts && !w_usts |=> usts_r == ($past(usts_r) | $past(uset)))
        else $error("native status changed by legacy clear");
    csts_keep_a: assert property (w_lsts |=> csts_r == ($past(csts_r) | $past(cset)))
        else $error("correctable status changed by legacy clear");
    lsts_set_a: assert property ((send_fat || send_nf) && serr_en |=> lsts_r[`LES_LSTS_SSE])
        else $error("legacy system error bit not set");
    sticky_a: assert property (usts_r[`LES_U_MAL] && !w_usts |=> usts_r[`LES_U_MAL])
        else $error("status bit dropped without clear");
    rd_lat_a: assert property (i_rd && i_addr == `LES_DCAP |=> o_rdata[`LES_DCAP_RBER] == rber)
        else $error("capability bit read wrong");
    rd_idle_a: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
    irq_level_a: assert property (!w_ien |=> o_irq == |(irq_sts_r & irq_en_r))
        else $error("interrupt level disagrees with status");

    fat_sent_c: cover property (o_msg.valid && o_msg.kind == LES_MSG_FAT);
    ur_posted_c: cover property (i_err.ur && i_err.ur_posted && serr_en ##1 o_msg.valid);
    irq_c: cover property (!o_irq ##1 o_irq);
    ur_adv_c: cover property (ur_cor ##1 o_msg.valid);
    hdr_log_c: cover property (hdr_take ##1 hdr_vld_r);

endmodule

/* tb/les_rc_model.sv */
// Purpose: root complex end that takes error messages off the link
// Assumes: messages are one-cycle pulses on the core clock
// Notes:   keeps a count and the class of the latest message
`timescale 1ns/1ps

module les_rc_model (
    input  wire logic              i_core_clk, // core clock
    input  wire logic              i_rstn,     // async reset, active low
    input  wire les_pkg::les_msg_t i_msg,      // message request from the block
    output logic [15:0]            o_count,    // messages taken so far
    output les_pkg::les_kind_t     o_last      // class of the latest message
);
    import les_pkg::*;

    // ****************************************
    // message sink
    // ****************************************
    // every valid cycle is one message, so a stretched pulse counts once per cycle
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_count <= 16'h0000;
            o_last  <= LES_MSG_COR;
        end else if (i_msg.valid) begin
            o_count <= o_count + 16'h0001;
            o_last  <= i_msg.kind;
        end
    end
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench for the link error block
// Assumes: register port answers one cycle after the read strobe
// Notes:   message classes are seen through the root complex model
`timescale 1ns/1ps
`include "les_defs.svh"

`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module tb_top;
    import les_pkg::*;

    localparam logic [127:0] HDR_A = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    localparam logic [127:0] HDR_B = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
    localparam logic [127:0] HDR_C = 128'hCAFE_0001_BEEF_0002_D00D_0003_F00D_0004;

    logic         i_core_clk      = 1'b0;
    logic         i_rstn          = 1'b0;
    les_err_t     i_err           = les_err_t'(7'h00);
    logic [127:0] i_hdr           = 128'h0;
    logic [7:0]   i_addr          = 8'h00;
    logic [31:0]  i_wdata         = 32'h0000_0000;
    logic         i_wr            = 1'b0;
    logic         i_rd            = 1'b0;
    logic [31:0]  o_rdata;
    les_msg_t     o_msg;
    logic         o_irq;
    logic [15:0]  rc_count;
    les_kind_t    rc_last;
    int           failures        = 0;
    int           samples_checked = 0;

    // 25 ns period core clock
    always #12.5 i_core_clk = ~i_core_clk;

    les_top DUT (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_err(i_err), .i_hdr(i_hdr),
                 .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
                 .o_rdata(o_rdata), .o_msg(o_msg), .o_irq(o_irq));

    les_rc_model RC (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_msg(o_msg),
                     .o_count(rc_count), .o_last(rc_last));

    // ****************************************
    // access tasks
    // ****************************************
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_core_clk);
        i_wr    <= 1'b0;
    endtask

    // read data is looked at only in the cycle after the strobe
    task automatic reg_rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_core_clk);
        i_rd   <= 1'b0;
        #1;
        `CHK(nm, exp, o_rdata)
    endtask

    // one event pulse, then count what reached the root complex
    task automatic raise(input string nm, input logic [6:0] e, input logic [127:0] h,
                         input logic exp_n, input les_kind_t exp_k);
        logic [15:0] cnt0;
        cnt0 = rc_count;
        @(posedge i_core_clk);
        i_err <= les_err_t'(e);
        i_hdr <= h;
        @(posedge i_core_clk);
        i_err <= les_err_t'(7'h00);
        @(posedge i_core_clk);
        #1;
        `CHK(nm, {15'h0000, exp_n}, rc_count - cnt0)
        if (exp_n) begin
            `CHK(nm, exp_k, rc_last)
        end
    endtask

    // ****************************************
    // watchdog
    // ****************************************
    // the tests need about 130 cycles, so 4000 means a hang
    initial begin
        repeat (4000) @(posedge i_core_clk);
        failures++;
        conclude();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        reg_rd("dcap", `LES_DCAP, 32'h0000_8000);
        reg_rd("usev", `LES_USEV, 32'h0006_2000);
        reg_rd("unmapped", 8'h40, 32'h0000_0000);
        $display("test reset values done");
        raise("mal quiet", 7'h10, HDR_A, 1'b0, LES_MSG_COR);
        reg_rd("usts mal", `LES_USTS, 32'h0004_0000);
        reg_rd("dsts mal", `LES_DSTS, 32'h0000_0004);
        reg_rd("hdr0", `LES_HDR0, HDR_A[31:0]);
        reg_rd("hdr3", `LES_HDR0 + 8'h0C, HDR_A[127:96]);
        $display("test silent detection done");
        reg_wr(`LES_DCTL, 32'h0000_0007);
        reg_wr(`LES_IRQ_EN, 32'h0000_0004);
        raise("overflow", 7'h40, HDR_B, 1'b1, LES_MSG_FAT);
        `CHK("irq up", 1'b1, o_irq)
        raise("fc error", 7'h20, HDR_B, 1'b1, LES_MSG_FAT);
        raise("mal fatal", 7'h10, HDR_B, 1'b1, LES_MSG_FAT);
        reg_rd("hdr kept", `LES_HDR0, HDR_A[31:0]);
        reg_wr(`LES_IRQ_CLR, 32'h0000_0004);
        reg_rd("irq sts", `LES_IRQ_STS, 32'h0000_0008);
        `CHK("irq down", 1'b0, o_irq)
        $display("test fatal messages done");
        reg_wr(`LES_CMD, 32'h0000_0100);
        raise("mal serr", 7'h10, HDR_B, 1'b1, LES_MSG_FAT);
        reg_rd("lsts set", `LES_LSTS, 32'h0000_4000);
        reg_wr(`LES_LSTS, 32'h0000_4000);
        reg_rd("lsts clr", `LES_LSTS, 32'h0000_0000);
        reg_rd("usts kept", `LES_USTS, 32'h0006_2000);
        reg_wr(`LES_USTS, 32'h0000_0000);
        reg_rd("usts w0", `LES_USTS, 32'h0006_2000);
        raise("fc serr", 7'h20, HDR_B, 1'b1, LES_MSG_FAT);
        reg_wr(`LES_USTS, 32'hFFFF_FFFF);
        reg_rd("usts w1", `LES_USTS, 32'h0000_0000);
        reg_rd("lsts kept", `LES_LSTS, 32'h0000_4000);
        $display("test legacy mapping done");
        raise("pfx block", 7'h08, HDR_C, 1'b1, LES_MSG_NF);
        reg_rd("hdr pfx", `LES_HDR0, HDR_C[31:0]);
        raise("pfx adv", 7'h04, HDR_B, 1'b1, LES_MSG_COR);
        reg_rd("csts adv", `LES_CSTS, 32'h0000_2000);
        reg_rd("usts pfx", `LES_USTS, 32'h0200_0000);
        $display("test prefix blocking done");
        reg_wr(`LES_USTS, 32'hFFFF_FFFF);
        reg_wr(`LES_DCTL, 32'h0000_0000);
        raise("ur np", 7'h02, HDR_B, 1'b0, LES_MSG_COR);
        raise("ur posted", 7'h03, HDR_B, 1'b1, LES_MSG_NF);
        reg_rd("usts ur", `LES_USTS, 32'h0010_0000);
        reg_wr(`LES_UMSK, 32'h0010_0000);
        raise("ur masked", 7'h03, HDR_B, 1'b0, LES_MSG_COR);
        reg_wr(`LES_UMSK, 32'h0000_0000);
        reg_wr(`LES_CMD, 32'h0000_0000);
        raise("ur off", 7'h03, HDR_B, 1'b0, LES_MSG_COR);
        reg_wr(`LES_DCTL, 32'h0000_000A);
        raise("ur on", 7'h03, HDR_B, 1'b1, LES_MSG_NF);
        reg_wr(`LES_DCTL, 32'h0000_0009);
        raise("ur adv", 7'h02, HDR_B, 1'b1, LES_MSG_COR);
        reg_rd("dsts all", `LES_DSTS, 32'h0000_000F);
        reg_wr(`LES_DSTS, 32'h0000_000F);
        reg_rd("dsts clr", `LES_DSTS, 32'h0000_0000);
        $display("test unsupported requests done");
        conclude();
    end
endmodule
